// File: hw/controlled_stop_sequencer.sv
// Controlled stop sequencer: trigger arbitration, stop methods, dwell
`timescale 1ns/1ps
module controlled_stop_sequencer
    import cstop_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int FREQ_W   = 16
) (
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    // Configuration
    input  wire logic [1:0]        stop_mode_i,
    input  wire logic [1:0]        dci_method_i,
    input  wire logic [1:0]        freq_method_i,
    input  wire logic              dci_active_high_i,
    input  wire logic [FREQ_W-1:0] freq_threshold_i,
    input  wire logic [FREQ_W-1:0] low_speed_i,
    input  wire logic              cfg_default_i,
    input  wire logic [6:0]        dc_level_pct_i,
    input  wire logic [9:0]        dc_time_ds_i,
    input  wire logic              shutdown_en_i,
    input  wire logic              shutdown_out_assign_i,
    input  wire logic [9:0]        dwell_ds_i,
    // Commands and drive state
    input  wire logic              discrete_control_input_i,
    input  wire logic              keypad_mode_i,
    input  wire logic              run_cmd_i,
    input  wire logic [FREQ_W-1:0] out_freq_i,
    input  wire logic              motor_at_rest_i,
    input  wire logic              power_loss_i,
    input  wire logic              drive_fault_i,
    // To ramp generator and output stage
    output logic                   run_o,
    output logic                   ramp_decel_o,
    output logic                   fast_decel_o,
    output logic                   hold_low_speed_o,
    output logic                   output_enable_o,
    output logic                   dc_inject_o,
    output logic [6:0]             dc_level_pct_o,
    // Status
    output logic [2:0]             state_o,
    output logic [1:0]             method_o,
    output logic                   shutdown_done_o,
    output logic                   config_error_o
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // True when method a outranks method b
    function automatic logic outranks(input logic [1:0] a, input logic [1:0] b);
        outranks = (a < b);
    endfunction

    // Stop state for a method, freewheel when power or drive is bad
    function automatic seq_state_t method_state(input logic [1:0] m,
                                                input logic       bad);
        seq_state_t s;
        s = ST_FREEWHEEL;
        if (!bad) begin
            case (m)
                STOP_FAST: s = ST_FAST;
                STOP_DC:   s = ST_DC_BRAKE;
                default:   s = ST_FREEWHEEL;
            endcase
        end
        method_state = s;
    endfunction

    // Clamp a setting into a legal range
    function automatic logic [9:0] clamp10(input logic [9:0] v,
                                           input logic [9:0] lo,
                                           input logic [9:0] hi);
        clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ------------------------------------------------------------
    // Timer blocks
    // ------------------------------------------------------------
    stop_timer_if #(.W(TIME_W)) tmr ();

    stop_tick_div #(
        .TICK_CYCLES (TICK_CYC)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tmr       (tmr.divider)
    );

    stop_countdown #(
        .W (TIME_W)
    ) u_cnt (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tmr       (tmr.timer)
    );

    // ------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------
    logic [6:0] dc_level_set;
    logic [9:0] dc_time_set;
    logic [9:0] dwell_set;
    logic       dc_continuous;
    logic [9:0] dc_load;

    // Out of range entries are clamped rather than refused
    always_comb begin
        if (cfg_default_i) begin
            dc_level_set = DC_LVL_DEF_PCT;
            dc_time_set  = DC_TIME_DEF_DS;
            dwell_set    = DWELL_DEF_DS;
        end else begin
            dc_level_set = (dc_level_pct_i < DC_LVL_MIN_PCT) ? DC_LVL_MIN_PCT :
                           ((dc_level_pct_i > DC_LVL_MAX_PCT) ? DC_LVL_MAX_PCT :
                            dc_level_pct_i);
            dc_time_set  = clamp10(dc_time_ds_i, DC_TIME_MIN_DS,
                                   DC_TIME_CONT_DS);
            dwell_set    = clamp10(dwell_ds_i, DWELL_MIN_DS,
                                   DWELL_MAX_DS);
        end
    end

    // The continuous setting brakes the full 30 s first
    assign dc_continuous = (dc_time_set == DC_TIME_CONT_DS);
    assign dc_load       = dc_continuous ? DC_TIME_MAX_DS : dc_time_set;

    // ------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------
    cs_mode_t mode;
    logic     dci_trig_en;
    logic     freq_trig_en;
    logic     shut_eff;
    logic     dci_asserted;
    logic     bad_drive;
    logic     stop_cmd;
    logic     dci_hit;
    logic     freq_hit;
    logic     any_hit;
    logic [1:0] cand;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [1:0] method_r;
    logic [1:0] method_nxt;
    logic       in_stop;

    assign mode = cs_mode_t'(stop_mode_i);
    // Input trigger is dropped under keypad command
    assign dci_trig_en  = ((mode == CS_DCI) || (mode == CS_BOTH))
                          && !keypad_mode_i;
    // Threshold trigger ignores the command source
    assign freq_trig_en = (mode == CS_FREQ) || (mode == CS_BOTH);
    // Shutdown cannot coexist with a threshold stop
    assign shut_eff       = shutdown_en_i && !freq_trig_en;
    assign config_error_o = shutdown_en_i && freq_trig_en;
    assign dci_asserted = (discrete_control_input_i == dci_active_high_i);
    assign bad_drive    = power_loss_i || drive_fault_i;
    assign stop_cmd     = !run_cmd_i;
    assign in_stop = (state_r == ST_FREEWHEEL) || (state_r == ST_FAST) ||
                     (state_r == ST_DC_BRAKE);
    assign dci_hit  = dci_trig_en && dci_asserted && (state_r != ST_IDLE) &&
                      (state_r != ST_DC_HOLD);
    // Threshold only counts while a stop command is in progress
    assign freq_hit = freq_trig_en && stop_cmd &&
                      ((state_r == ST_DECEL) || in_stop) &&
                      (out_freq_i <= freq_threshold_i);
    assign any_hit  = dci_hit || freq_hit;
    // Input trigger's method takes precedence on a tie
    assign cand = dci_hit ? dci_method_i : freq_method_i;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        method_nxt = method_r;
        case (state_r)
            ST_IDLE: begin
                // Reached only after any dwell ends, so a held run waits
                if (run_cmd_i && !bad_drive) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (bad_drive) begin
                    state_nxt  = ST_FREEWHEEL;
                    method_nxt = STOP_FREEWHEEL;
                end else if (dci_hit) begin
                    state_nxt  = method_state(cand, bad_drive);
                    method_nxt = cand;
                end else if (stop_cmd) begin
                    state_nxt = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (bad_drive) begin
                    state_nxt  = ST_FREEWHEEL;
                    method_nxt = STOP_FREEWHEEL;
                end else if (any_hit) begin
                    state_nxt  = method_state(cand, bad_drive);
                    method_nxt = cand;
                end else if (run_cmd_i) begin
                    state_nxt = ST_RUN;
                end else if (shut_eff && out_freq_i <= low_speed_i) begin
                    state_nxt = ST_DWELL;
                end else if (motor_at_rest_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_FREEWHEEL: begin
                // Highest rank: nothing can displace it
                if (motor_at_rest_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_FAST, ST_DC_BRAKE: begin
                if (bad_drive) begin
                    state_nxt  = ST_FREEWHEEL;
                    method_nxt = STOP_FREEWHEEL;
                end else if (any_hit && outranks(cand, method_r)) begin
                    state_nxt  = method_state(cand, bad_drive);
                    method_nxt = cand;
                end else if (state_r == ST_FAST && motor_at_rest_i) begin
                    state_nxt = ST_IDLE;
                end else if (state_r == ST_DC_BRAKE && tmr.expired) begin
                    state_nxt = dc_continuous ? ST_DC_HOLD : ST_IDLE;
                end
            end
            ST_DC_HOLD: begin
                // Continuous hold ends on a fault or a new run request
                if (bad_drive || run_cmd_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DWELL: begin
                if (bad_drive) begin
                    state_nxt  = ST_FREEWHEEL;
                    method_nxt = STOP_FREEWHEEL;
                end else if (dci_hit) begin
                    state_nxt  = method_state(cand, bad_drive);
                    method_nxt = cand;
                end else if (tmr.expired) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_r  <= ST_IDLE;
            method_r <= STOP_FREEWHEEL;
        end else begin
            state_r  <= state_nxt;
            method_r <= method_nxt;
        end
    end

    // ------------------------------------------------------------
    // Timer control
    // ------------------------------------------------------------
    logic       tmr_start_r;
    logic [9:0] tmr_load_r;

    // Countdown starts on entry to braking or dwell
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tmr_start_r <= 1'b0;
            tmr_load_r  <= '0;
        end else begin
            tmr_start_r <= 1'b0;
            if (state_nxt == ST_DC_BRAKE && state_r != ST_DC_BRAKE) begin
                tmr_start_r <= 1'b1;
                tmr_load_r  <= dc_load;
            end else if (state_nxt == ST_DWELL && state_r != ST_DWELL) begin
                tmr_start_r <= 1'b1;
                tmr_load_r  <= dwell_set;
            end
        end
    end

    assign tmr.start = tmr_start_r;
    assign tmr.load  = tmr_load_r;

    // ------------------------------------------------------------
    // Shutdown status
    // ------------------------------------------------------------
    logic shut_done_r;

    // Held from dwell end until the next run begins
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shut_done_r <= 1'b0;
        end else if (state_r == ST_DWELL && state_nxt == ST_IDLE) begin
            shut_done_r <= shutdown_out_assign_i;
        end else if (state_nxt == ST_RUN) begin
            shut_done_r <= 1'b0;
        end
    end

    assign shutdown_done_o = shut_done_r;

    // ------------------------------------------------------------
    // Output stage and ramp requests
    // ------------------------------------------------------------
    // Registered from the next state so they align with state_o
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            run_o            <= 1'b0;
            ramp_decel_o     <= 1'b0;
            fast_decel_o     <= 1'b0;
            hold_low_speed_o <= 1'b0;
            output_enable_o  <= 1'b0;
            dc_inject_o      <= 1'b0;
            dc_level_pct_o   <= '0;
        end else begin
            run_o            <= (state_nxt == ST_RUN);
            ramp_decel_o     <= (state_nxt == ST_DECEL);
            fast_decel_o     <= (state_nxt == ST_FAST);
            hold_low_speed_o <= (state_nxt == ST_DWELL);
            // Freewheel and idle leave the bridge off
            output_enable_o  <= (state_nxt != ST_IDLE) &&
                                (state_nxt != ST_FREEWHEEL);
            dc_inject_o      <= (state_nxt == ST_DC_BRAKE) ||
                                (state_nxt == ST_DC_HOLD);
            if (state_nxt == ST_DC_HOLD) begin
                dc_level_pct_o <= DC_HOLD_PCT;
            end else if (state_nxt == ST_DC_BRAKE) begin
                dc_level_pct_o <= dc_level_set;
            end else begin
                dc_level_pct_o <= '0;
            end
        end
    end

    // Status mirrors of the sequencer
    assign state_o  = state_r;
    assign method_o = method_r;

endmodule

// File: hw/cstop_pkg.sv
// Shared constants and types for the controlled stop sequencer
package cstop_pkg;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ   = 250_000;    // 250 MHz core clock
    localparam int TIME_STEP_MS   = 100;        // Setting resolution, 0.1 s
    localparam int TICK_CYCLES    = TIME_STEP_MS * CLK_FREQ_KHZ;
    localparam int TIME_W         = 10;         // Width of time settings

    // ------------------------------------------------------------
    // Time settings, in 0.1 s steps
    // ------------------------------------------------------------
    localparam logic [9:0] DC_TIME_MIN_DS  = 10'h000;  // 0 s
    localparam logic [9:0] DC_TIME_MAX_DS  = 10'h12C;  // 30 s
    localparam logic [9:0] DC_TIME_CONT_DS = 10'h12D;  // 30.1 s: continuous
    localparam logic [9:0] DC_TIME_DEF_DS  = 10'h014;  // 2 s
    localparam logic [9:0] DWELL_MIN_DS    = 10'h001;  // 0.1 s
    localparam logic [9:0] DWELL_MAX_DS    = 10'h258;  // 60 s
    localparam logic [9:0] DWELL_DEF_DS    = 10'h00A;  // 1 s

    // ------------------------------------------------------------
    // Injection current, percent of nominal drive current
    // ------------------------------------------------------------
    localparam logic [6:0] DC_LVL_MIN_PCT  = 7'h32;    // 50 %
    localparam logic [6:0] DC_LVL_MAX_PCT  = 7'h6E;    // 110 %
    localparam logic [6:0] DC_LVL_DEF_PCT  = 7'h46;    // 70 %
    localparam logic [6:0] DC_HOLD_PCT     = 7'h32;    // 50 % of rated

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CS_OFF  = 2'h0,
        CS_DCI  = 2'h1,
        CS_FREQ = 2'h2,
        CS_BOTH = 2'h3
    } cs_mode_t;

    // Lower code ranks higher
    typedef enum logic [1:0] {
        STOP_FREEWHEEL = 2'h0,
        STOP_FAST      = 2'h1,
        STOP_DC        = 2'h2
    } stop_method_t;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_RUN       = 3'h1,
        ST_DECEL     = 3'h2,
        ST_FREEWHEEL = 3'h3,
        ST_FAST      = 3'h4,
        ST_DC_BRAKE  = 3'h5,
        ST_DC_HOLD   = 3'h6,
        ST_DWELL     = 3'h7
    } seq_state_t;

endpackage

// File: hw/stop_timer_if.sv
// Timer carrier between sequencer, tick divider and countdown timer
`timescale 1ns/1ps
interface stop_timer_if #(
    parameter int W = 10
);
    logic         tick;     // One-cycle pulse per 0.1 s
    logic         start;    // Load and start a countdown
    logic [W-1:0] load;     // Countdown length in ticks
    logic         expired;  // One-cycle pulse at end of countdown
    logic         busy;     // Countdown running

    modport divider (output tick);
    modport timer   (input tick, input start, input load, output expired, output busy);
    modport ctrl    (input expired, input busy, output start, output load);
endinterface

// File: hw/stop_tick_div.sv
// Divider that makes the 0.1 s enable pulse
`timescale 1ns/1ps
module stop_tick_div #(
    parameter int TICK_CYCLES = 25_000_000
) (
    input  wire logic   ref_clk_i,
    input  wire logic   srst_i,
    stop_timer_if.divider tmr
);
    localparam int CW = $clog2(TICK_CYCLES);

    logic [CW-1:0] cnt_r;
    logic          tick_r;

    // Free running count, pulse on wrap
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == CW'(TICK_CYCLES - 1)) begin
            cnt_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    assign tmr.tick = tick_r;
endmodule

// File: hw/stop_countdown.sv
// Countdown timer in 0.1 s steps
`timescale 1ns/1ps
module stop_countdown #(
    parameter int W = 10
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    stop_timer_if.timer tmr
);
    logic [W-1:0] cnt_r;
    logic         busy_r;
    logic         exp_r;

    // Zero length expires two cycles after the start pulse
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            exp_r  <= 1'b0;
        end else if (tmr.start) begin
            cnt_r  <= tmr.load;
            busy_r <= 1'b1;
            exp_r  <= 1'b0;
        end else if (busy_r && cnt_r == '0) begin
            busy_r <= 1'b0;
            exp_r  <= 1'b1;
        end else begin
            exp_r <= 1'b0;
            if (busy_r && tmr.tick) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign tmr.expired = exp_r;
    assign tmr.busy    = busy_r;
endmodule

// File: tb/motor_model.sv
// Motor and output stage model on the far side of the sequencer
`timescale 1ns/1ps
module motor_model (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        run_i,
    input  wire logic        hold_i,
    output logic      [15:0] out_freq_o,
    output logic             motor_at_rest_o
);
    // Full speed while running, frozen in dwell, else slows a step a cycle
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || run_i)
            out_freq_o <= srst_i ? 16'h0000 : 16'h00C8;
        else if (!hold_i && out_freq_o != 16'h0000)
            out_freq_o <= out_freq_o - 16'h0001;
    end
    // Standstill only once the shaft has truly stopped
    assign motor_at_rest_o = (out_freq_o == 16'h0000);
endmodule

// File: tb/stop_seq_checker.sv
// Port-level assertions for the controlled stop sequencer
`timescale 1ns/1ps
module stop_seq_checker (
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic [1:0] stop_mode_i,
    input wire logic       shutdown_en_i,
    input wire logic       keypad_mode_i,
    input wire logic       run_cmd_i,
    input wire logic       power_loss_i,
    input wire logic       drive_fault_i,
    input wire logic       output_enable_o,
    input wire logic       fast_decel_o,
    input wire logic       dc_inject_o,
    input wire logic [6:0] dc_level_pct_o,
    input wire logic [2:0] state_o,
    input wire logic       config_error_o
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire healthy = !drive_fault_i && !power_loss_i;

    a_coast_output_off: assert property (state_o == 3'h3 |-> !output_enable_o)
        else $error("output stage on while coasting");
    a_fast_ramp_on: assert property (state_o == 3'h4 |-> fast_decel_o && output_enable_o)
        else $error("fast stop without fast ramp");
    a_fault_forces_coast: assert property (!healthy && state_o inside {3'h4, 3'h5}
        |=> state_o == 3'h3) else $error("active stop kept during fault");
    a_keypad_ignores_input: assert property (state_o == 3'h1 && keypad_mode_i && run_cmd_i
        && stop_mode_i == 2'h1 && healthy |=> state_o == 3'h1) else $error("input stop in keypad");
    a_inject_level_range: assert property (state_o == 3'h5 |-> dc_inject_o
        && dc_level_pct_o >= 7'h32 && dc_level_pct_o <= 7'h6E) else $error("bad injection level");
    a_hold_half_level: assert property (state_o == 3'h6 |-> dc_inject_o
        && dc_level_pct_o == 7'h32) else $error("hold level not half");
    a_shutdown_conflict: assert property (config_error_o == (shutdown_en_i && stop_mode_i[1]))
        else $error("shutdown conflict flag wrong");
    a_dwell_defers_run: assert property (state_o == 3'h7 && run_cmd_i && stop_mode_i == 2'h0
        && healthy |=> state_o inside {3'h7, 3'h0}) else $error("run acted on during dwell");
endmodule

bind controlled_stop_sequencer stop_seq_checker chk (.ref_clk_i, .srst_i, .stop_mode_i,
    .shutdown_en_i, .keypad_mode_i, .run_cmd_i, .power_loss_i, .drive_fault_i,
    .output_enable_o, .fast_decel_o, .dc_inject_o, .dc_level_pct_o, .state_o, .config_error_o);

// File: tb/controlled_stop_sequencer_bench.sv
// Self-checking bench for the controlled stop sequencer
`timescale 1ns/1ps
module controlled_stop_sequencer_bench;
    import cstop_pkg::*;
    logic        ref_clk_i, srst_i, dci_active_high_i, cfg_default_i, shutdown_en_i;
    logic        discrete_control_input_i, keypad_mode_i, run_cmd_i, power_loss_i;
    logic        drive_fault_i, motor_at_rest_i, run_o, ramp_decel_o, fast_decel_o;
    logic        hold_low_speed_o, output_enable_o, dc_inject_o, shutdown_done_o;
    logic        config_error_o, shutdown_out_assign_i;
    logic [1:0]  stop_mode_i, dci_method_i, freq_method_i, method_o;
    logic [2:0]  state_o;
    logic [6:0]  dc_level_pct_o, dc_level_pct_i;
    logic [9:0]  dc_time_ds_i;
    logic [15:0] out_freq_i;
    logic [9:0]  outs_exp [3] = '{10'h000, 10'h300, 10'h2C6};
    int          err_total, comparisons;

    // Short tick so timed stops finish quickly; threshold 100, low speed 50
    controlled_stop_sequencer #(.TICK_CYC(10), .FREQ_W(16)) dut (
        .ref_clk_i, .srst_i, .stop_mode_i, .dci_method_i, .freq_method_i, .dci_active_high_i,
        .freq_threshold_i(16'h0064), .low_speed_i(16'h0032), .cfg_default_i,
        .dc_level_pct_i, .dc_time_ds_i, .shutdown_en_i, .shutdown_out_assign_i,
        .dwell_ds_i(10'h005), .discrete_control_input_i, .keypad_mode_i, .run_cmd_i,
        .out_freq_i, .motor_at_rest_i, .power_loss_i, .drive_fault_i, .run_o, .ramp_decel_o,
        .fast_decel_o, .hold_low_speed_o, .output_enable_o, .dc_inject_o, .dc_level_pct_o,
        .state_o, .method_o, .shutdown_done_o, .config_error_o);
    motor_model motor (.ref_clk_i, .srst_i, .run_i(run_o), .hold_i(hold_low_speed_o),
        .out_freq_o(out_freq_i), .motor_at_rest_o(motor_at_rest_i));

    // 250 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // ---------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Bounded wait for a state, so a stuck sequencer cannot hang the run
    task automatic go(input logic [2:0] s);
        int n;
        n = 0;
        while (state_o !== s && n < 5000) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("state", state_o, s);
    endtask

    task automatic start();
        run_cmd_i = 1'b1;
        go(ST_RUN);
    endtask

    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ---------------------------------------------------------
    // Test sequence, inputs driven on falling edges
    // ---------------------------------------------------------
    initial begin
        {dci_active_high_i, cfg_default_i, shutdown_en_i, discrete_control_input_i} = 4'h0;
        {shutdown_out_assign_i, dc_level_pct_i} = {1'b1, 7'h50};
        {keypad_mode_i, run_cmd_i, power_loss_i, drive_fault_i} = 4'h0;
        {stop_mode_i, dci_method_i, freq_method_i, dc_time_ds_i} = {CS_OFF, 4'h0, 10'h000};
        srst_i = 1'b1;
        repeat (20) @(negedge ref_clk_i);
        srst_i = 1'b0;
        check("idle outs", {state_o, output_enable_o, run_o, dc_inject_o}, 16'h0000);
        start();
        run_cmd_i = 1'b0;
        go(ST_DECEL);
        check("ramp", ramp_decel_o, 1'b1);
        go(ST_IDLE);
        // Every method, alternating the input's active level
        for (int m = 0; m < 3; m++) begin
            {stop_mode_i, dci_method_i, dci_active_high_i} = {CS_DCI, 2'(m), m[0]};
            {cfg_default_i, discrete_control_input_i} = {1'b1, ~m[0]};
            start();
            discrete_control_input_i = m[0];
            go(3'(3 + m));
            check("outs", {output_enable_o, fast_decel_o, dc_inject_o, dc_level_pct_o}, outs_exp[m]);
            go(ST_IDLE);
        end
        {keypad_mode_i, dci_active_high_i, dci_method_i, discrete_control_input_i} = 5'h13;
        start();
        discrete_control_input_i = 1'b0; // Asserted, active low
        repeat (5) @(negedge ref_clk_i);
        check("keypad", state_o, ST_RUN);
        {stop_mode_i, freq_method_i, run_cmd_i} = {CS_FREQ, 2'h1, 1'b0};
        go(ST_DECEL);
        go(ST_FAST);
        check("at threshold", out_freq_i <= 16'h0064, 1'b1);
        drive_fault_i = 1'b1;
        go(ST_FREEWHEEL);
        drive_fault_i = 1'b0;
        go(ST_IDLE);
        // Input trigger first, then a higher-ranked threshold trigger
        {stop_mode_i, freq_method_i, keypad_mode_i, discrete_control_input_i} = 6'h31;
        start();
        {run_cmd_i, discrete_control_input_i} = 2'h0;
        go(ST_FAST);
        discrete_control_input_i = 1'b1; // Release so the threshold trigger alone decides
        go(ST_FREEWHEEL);
        check("method", method_o, STOP_FREEWHEEL);
        go(ST_IDLE);
        {stop_mode_i, dci_method_i, dc_time_ds_i, cfg_default_i} = {CS_DCI, 2'h2, 10'h12D, 1'b0};
        {discrete_control_input_i, run_cmd_i, dc_level_pct_i} = {2'h3, 7'h78};
        go(ST_RUN);
        {discrete_control_input_i, run_cmd_i} = 2'h0; // Stop held so the hold persists
        go(ST_DC_BRAKE);
        check("clamped level", dc_level_pct_o, DC_LVL_MAX_PCT);
        go(ST_DC_HOLD);
        check("hold level", dc_level_pct_o, 7'h32);
        discrete_control_input_i = 1'b1;
        start();
        {stop_mode_i, shutdown_en_i} = {CS_FREQ, 1'b1};
        @(negedge ref_clk_i);
        check("conflict", config_error_o, 1'b1);
        {stop_mode_i, run_cmd_i} = {CS_OFF, 1'b0};
        go(ST_DWELL);
        check("dwell", {hold_low_speed_o, out_freq_i <= 16'h0032}, 2'h3);
        run_cmd_i = 1'b1;
        repeat (20) @(negedge ref_clk_i);
        check("deferred", state_o, ST_DWELL);
        go(ST_IDLE);
        check("done", shutdown_done_o, 1'b1);
        go(ST_RUN);
        check("run", run_o, 1'b1);
        print_verdict();
    end

    // Watchdog well beyond the longest expected run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        print_verdict();
    end
endmodule
